// ---- rtl/bsu_pkg.sv ----
`default_nettype none
package bsu_pkg;
  localparam int BYTE_W = 8;
  localparam logic [7:0] START_ZERO = 8'h00;
  localparam logic [7:0] START_ONE = 8'h01;
  localparam logic [7:0] RESERVED_BYTE = 8'h02;
  localparam logic [7:0] ESCAPE_BYTE = 8'h03;
  localparam int SYNC_ZERO_BITS = 23;
  localparam int SHORT_ZEROS = 1;
  localparam int LONG_ZEROS = 2;
  localparam int TYPE_LSB = 0;
  localparam int TYPE_W = 5;
  localparam logic [4:0] LONG_TYPE_FIRST = 5'h06;
  localparam logic [4:0] LONG_TYPE_LAST = 5'h09;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_MARGIN = 8;
  localparam int WORD_W = BYTE_W + 2;
endpackage
`default_nettype wire

// ---- rtl/bsu_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bsu_link_if;
  logic serBit;
  logic serValid;
  logic serReady;
  modport framer (output serBit, output serValid, input serReady);
  modport deframer (input serBit, input serValid, output serReady);
endinterface
`default_nettype wire

// ---- rtl/unit_framer.sv ----
`timescale 1ns/1ps
`default_nettype none
module unit_framer import bsu_pkg::*; #(
  parameter int STUFF_BYTES = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  bsu_link_if.framer link,
  // Payload bytes in
  input wire logic inValid,
  input wire logic [7:0] inData,
  input wire logic inFirst,
  input wire logic forceLong,
  output logic inReady
);
  if (STUFF_BYTES < 0 || STUFF_BYTES + LONG_ZEROS > 7) begin : g_bad_stuff
    $error("unit_framer: STUFF_BYTES out of range");
  end

  typedef struct packed {
    logic [7:0] hold;
    logic holdFirst;
    logic holdValid;
    logic markDone;
    logic markerBusy;
    logic [2:0] zerosLeft;
    logic oneDue;
    logic lastZero;
    logic [7:0] sh;
    logic [2:0] bitsLeft;
    logic inReady;
    logic serBit;
    logic serValid;
  } fr_state_t;

  fr_state_t s_reg, s_next;
  logic [7:0] cand;
  logic candOk;
  logic consume;
  logic [7:0] sendByte;
  logic [4:0] unitType;
  logic wantLong;

  assign unitType = s_reg.hold[TYPE_LSB +: TYPE_W];
  assign wantLong = forceLong || (unitType >= LONG_TYPE_FIRST && unitType <= LONG_TYPE_LAST); // R7

  always_comb begin
    s_next = s_reg;
    s_next.serValid = 1'b0;
    cand = START_ZERO;
    candOk = 1'b0;
    consume = 1'b0;
    sendByte = START_ZERO;
    if (s_reg.inReady && inValid) begin
      s_next.hold = inData;
      s_next.holdFirst = inFirst;
      s_next.holdValid = 1'b1;
    end
    if (link.serReady) begin
      if (s_reg.bitsLeft != 3'd0) begin
        s_next.serBit = s_reg.sh[7]; // R1
        s_next.serValid = 1'b1;
        s_next.sh = {s_reg.sh[6:0], 1'b0};
        s_next.bitsLeft = s_reg.bitsLeft - 3'd1;
      end else begin
        if (s_reg.zerosLeft != 3'd0) begin
          cand = START_ZERO;
          candOk = 1'b1;
        end else if (s_reg.oneDue) begin
          cand = START_ONE;
          candOk = 1'b1;
        end else if (s_reg.holdValid && s_reg.holdFirst && !s_reg.markDone) begin
          // Exactly one marker ahead of each unit, stuffing in front of it
          s_next.zerosLeft = wantLong ? 3'(LONG_ZEROS + STUFF_BYTES) // R2 R4 R5
                                      : 3'(SHORT_ZEROS + STUFF_BYTES); // R3
        end else if (s_reg.holdValid) begin
          cand = s_reg.hold; // R8
          candOk = 1'b1;
          consume = 1'b1;
        end
        if (candOk) begin
          // A payload zero followed by anything up to 0x03 gets an escape between,
          // which also keeps the reserved pair off the line
          if (!s_reg.markerBusy && s_reg.lastZero && cand <= ESCAPE_BYTE) begin
            sendByte = ESCAPE_BYTE; // R9
            s_next.lastZero = 1'b0;
          end else begin
            sendByte = cand;
            s_next.lastZero = (cand == START_ZERO);
            if (s_reg.zerosLeft != 3'd0) begin
              s_next.zerosLeft = s_reg.zerosLeft - 3'd1;
              s_next.markerBusy = 1'b1;
              s_next.oneDue = (s_reg.zerosLeft == 3'd1);
            end else if (s_reg.oneDue) begin
              s_next.oneDue = 1'b0;
              s_next.markerBusy = 1'b0;
              s_next.markDone = 1'b1;
              s_next.lastZero = 1'b0;
            end else if (consume) begin
              s_next.holdValid = 1'b0;
              s_next.markDone = 1'b0;
            end
          end
          s_next.serBit = sendByte[7]; // R1
          s_next.serValid = 1'b1;
          s_next.sh = {sendByte[6:0], 1'b0};
          s_next.bitsLeft = 3'd7;
        end
      end
    end
    s_next.inReady = !s_next.holdValid;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.serBit = s_reg.serBit;
  assign link.serValid = s_reg.serValid;
  assign inReady = s_reg.inReady;
endmodule
`default_nettype wire

// ---- rtl/unit_deframer.sv ----
// Notes on behaviour
// R1: Bits travel MSB first, byte after byte.
// R2: Each framed unit: one marker, one payload.
// R3: Short marker is 0x00 then 0x01.
// R4: Long marker is 0x00 0x00 0x01.
// R5: Zero stuffing before marker is accepted silently.
// R6: Zero bytes are discarded until a marker.
// R7: Types 0x06 to 0x09 use long marker.
// R8: Units leave in decoding order.
// R9: Pair 0x00 0x02 never sent.
// R10: Alignment from 23 zero bits then one.
// R11: 0x00 0x01 is marker; long after zero.
// R12: Byte 0x03 after zero is dropped.
// R13: Payload delivered bare, first byte flagged.
`timescale 1ns/1ps
`default_nettype none
module unit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady,
  // Words held in memory
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_fifo
    $error("unit_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } fifo_state_t;

  fifo_state_t s_reg, s_next;
  logic push;
  logic pop;

  assign inReady = (s_reg.cnt < (AW+1)'(DEPTH));
  assign push = inValid && inReady;

  always_comb begin
    s_next = s_reg;
    // Output stage refills whenever it is empty or being taken
    pop = (s_reg.cnt != '0) && (!s_reg.outValid || outReady);
    if (outReady) begin
      s_next.outValid = 1'b0;
    end
    if (pop) begin
      s_next.outData = s_reg.mem[s_reg.rp];
      s_next.outValid = 1'b1;
      s_next.rp = s_reg.rp + AW'(1);
    end
    if (push) begin
      s_next.mem[s_reg.wp] = inData;
      s_next.wp = s_reg.wp + AW'(1);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign outValid = s_reg.outValid;
  assign outData = s_reg.outData;
  assign level = s_reg.cnt;
endmodule

module unit_deframer import bsu_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Serial link
  bsu_link_if.deframer link,
  // Alignment control and status
  input wire logic resync,
  output logic aligned,
  // Payload bytes out
  output logic outValid,
  output logic [7:0] outData,
  output logic outFirst,
  output logic outLong,
  input wire logic outReady
);
  localparam int READY_LIMIT = DEPTH - FIFO_MARGIN;
  if (DEPTH < 2 * FIFO_MARGIN) begin : g_bad_depth
    $error("unit_deframer: DEPTH too small for link stall margin");
  end

  typedef enum logic [0:0] {MODE_HUNT, MODE_ALIGNED} mode_t;

  typedef struct packed {
    mode_t mode;
    logic [4:0] zeroRun;
    logic [2:0] bitCnt;
    logic [7:0] sh;
    logic [1:0] zc;
    logic firstDue;
    logic unitLong;
    logic [1:0] emitZeros;
    logic emitByteValid;
    logic [7:0] emitByte;
    logic serReady;
    logic aligned;
  } df_state_t;

  df_state_t s_reg, s_next;
  logic [7:0] b;
  logic pushValid;
  logic [WORD_W-1:0] pushWord;
  logic pushReady;
  logic [$clog2(DEPTH):0] level;
  logic [WORD_W-1:0] headWord;

  assign b = {s_reg.sh[6:0], link.serBit}; // R1

  always_comb begin
    s_next = s_reg;
    pushValid = 1'b0;
    pushWord = '0;
    // Drain pending zeros first, then the byte that released them
    if (s_reg.emitZeros != 2'd0 || s_reg.emitByteValid) begin
      pushValid = 1'b1;
      pushWord = {s_reg.firstDue, s_reg.unitLong,
                  (s_reg.emitZeros != 2'd0) ? START_ZERO : s_reg.emitByte}; // R13
      if (pushReady) begin
        s_next.firstDue = 1'b0;
        if (s_reg.emitZeros != 2'd0) begin
          s_next.emitZeros = s_reg.emitZeros - 2'd1;
        end else begin
          s_next.emitByteValid = 1'b0;
        end
      end
    end
    if (resync) begin
      s_next.mode = MODE_HUNT;
      s_next.zeroRun = '0;
      s_next.zc = '0;
    end else if (link.serValid) begin
      case (s_reg.mode)
        MODE_HUNT: begin
          if (!link.serBit) begin
            if (s_reg.zeroRun < 5'(SYNC_ZERO_BITS)) begin
              s_next.zeroRun = s_reg.zeroRun + 5'd1;
            end
          end else if (s_reg.zeroRun == 5'(SYNC_ZERO_BITS)) begin
            // The pattern is a long marker, so a unit starts next
            s_next.mode = MODE_ALIGNED; // R10
            s_next.bitCnt = '0;
            s_next.zc = '0;
            s_next.firstDue = 1'b1;
            s_next.unitLong = 1'b1;
          end else begin
            s_next.zeroRun = '0;
          end
        end
        MODE_ALIGNED: begin
          s_next.sh = b;
          s_next.bitCnt = s_reg.bitCnt + 3'd1;
          if (s_reg.bitCnt == 3'd7) begin
            if (b == START_ZERO) begin
              // A zero run longer than two cannot be payload, so the
              // extra zeros are stuffing and are dropped
              s_next.zc = (s_reg.zc == 2'd2) ? 2'd2 : s_reg.zc + 2'd1; // R5 R6
            end else if (b == START_ONE && s_reg.zc != 2'd0) begin
              s_next.unitLong = (s_reg.zc >= 2'(LONG_ZEROS)); // R11
              s_next.firstDue = 1'b1; // R13
              s_next.zc = '0;
            end else if (b == ESCAPE_BYTE && s_reg.zc != 2'd0) begin
              s_next.emitZeros = s_reg.zc; // R12
              s_next.zc = '0;
            end else begin
              s_next.emitZeros = s_reg.zc;
              s_next.emitByte = b;
              s_next.emitByteValid = 1'b1;
              s_next.zc = '0;
            end
          end
        end
        default: begin
          s_next.mode = MODE_HUNT;
        end
      endcase
    end
    // Margin covers bits already in flight when the stall is seen
    s_next.serReady = (int'(level) <= READY_LIMIT);
    s_next.aligned = (s_next.mode == MODE_ALIGNED);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  unit_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inData(pushWord),
    .inReady(pushReady),
    .outValid(outValid),
    .outData(headWord),
    .outReady(outReady),
    .level(level)
  );

  assign outData = headWord[7:0];
  assign outLong = headWord[8];
  assign outFirst = headWord[9];
  assign link.serReady = s_reg.serReady;
  assign aligned = s_reg.aligned;
endmodule
`default_nettype wire

// ---- tb/bsu_link_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module bsu_link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  input wire logic serBit,
  input wire logic serValid,
  input wire logic serReady
);
  logic [2:0] bitReg;
  logic [5:0] seenReg;
  logic [6:0] shReg;
  logic [31:0] histReg;
  logic doneReg;
  // Byte history assumes no stuffing bytes, so 00 00 only opens a long marker
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bitReg <= 3'h0;
      seenReg <= 6'h0;
      shReg <= 7'h0;
      histReg <= 32'h0;
      doneReg <= 1'b0;
    end else begin
      doneReg <= serValid && bitReg == 3'h7;
      if (serValid) begin
        bitReg <= bitReg + 3'h1;
        shReg <= {shReg[5:0], serBit};
        if (bitReg == 3'h7) histReg <= {histReg[23:0], shReg, serBit};
        if (seenReg != 6'h3F) seenReg <= seenReg + 6'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !serValid && !serReady)
    else $error("link active in reset");
  a_ready_wakes: assert property ($rose(nrst) |-> ##[0:2] serReady)
    else $error("ready missing after reset");
  a_stall_honoured: assert property (!serReady [*3] |-> !serValid)
    else $error("bit sent while stalled");
  a_sync_zeros: assert property (serValid && seenReg < 6'd23 |-> !serBit)
    else $error("sync run not zero");
  a_sync_one: assert property (serValid && seenReg == 6'd23 |-> serBit)
    else $error("sync run not ended by one");
  a_no_reserved: assert property (doneReg && seenReg > 6'd15 |-> histReg[15:0] != 16'h0002)
    else $error("reserved pair sent");
  a_zeros_marker: assert property (doneReg && seenReg > 6'd23 && histReg[23:8] == 16'h0
    |-> histReg[7:0] == 8'h01)
    else $error("zero pair not a marker");
  a_long_type: assert property (doneReg && seenReg > 6'd31 && histReg[23:8] == 16'h0001
    && histReg[4:0] inside {[5'h06:5'h09]} |-> histReg[31:24] == 8'h00)
    else $error("short marker on long type");
endmodule
`default_nettype wire

// ---- tb/byte_stream_unit_framer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_stream_unit_framer_bench;
  localparam logic [7:0] PAY [0:18] = '{8'h07, 8'hAA, 8'h00, 8'h03, 8'h55, 8'h05, 8'h00,
    8'h01, 8'h00, 8'h02, 8'h11, 8'h06, 8'h00, 8'h00, 8'h22, 8'h01, 8'h33, 8'h09, 8'h44};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic inValid = 1'b0;
  logic inFirst = 1'b0;
  logic forceLong = 1'b0;
  logic resync = 1'b0;
  logic outReady = 1'b0;
  logic stall = 1'b0;
  logic stalled = 1'b0;
  logic [7:0] inData = 8'h00;
  logic inReady, aligned, outValid, outFirst, outLong;
  logic [7:0] outData;
  logic [31:0] wireReg = 32'h0;
  logic [9:0] expQ[$];
  int badCount = 0;
  int nTests = 0;
  int cycles = 0;
  int nBits = 0;
  int rx = 0;
  bsu_link_if link();
  unit_framer u_unit_framer (.clk(clk), .nrst(nrst), .link(link), .inValid(inValid),
    .inData(inData), .inFirst(inFirst), .forceLong(forceLong), .inReady(inReady));
  unit_deframer u_unit_deframer (.clk(clk), .nrst(nrst), .link(link), .resync(resync),
    .aligned(aligned), .outValid(outValid), .outData(outData), .outFirst(outFirst),
    .outLong(outLong), .outReady(outReady));
  bsu_link_asserts u_bsu_link_asserts (.clk(clk), .nrst(nrst), .serBit(link.serBit),
    .serValid(link.serValid), .serReady(link.serReady));
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finalReport();
    $display("Checks %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected entry is {first, long, data}
  task automatic send(input logic [7:0] d, input logic f, input logic l);
    inValid <= 1'b1;
    inData <= d;
    inFirst <= f;
    expQ.push_back({f, l, d});
    @(posedge clk);
    while (inReady !== 1'b1) @(posedge clk);
  endtask
  task automatic unit(input int s, input int n, input logic fl, input logic lg);
    forceLong <= fl;
    for (int i = 0; i < n; i++) send(PAY[s+i], i == 0, lg);
    inValid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic drain();
    while (rx != expQ.size()) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Consumer holds off until the link has pushed back
    outReady <= !(stall && !stalled);
    if (stall && link.serReady === 1'b0) stalled <= 1'b1;
    if (link.serValid === 1'b1 && nBits < 32) begin
      wireReg <= {wireReg[30:0], link.serBit};
      nBits <= nBits + 1;
    end
    if (outValid === 1'b1 && outReady === 1'b1) begin
      check(32'({outFirst, outLong, outData}), 32'(expQ[rx]));
      rx <= rx + 1;
    end
    // Ending the run is the last thing this process does
    if (cycles == 20000) begin
      badCount++;
      finalReport();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    unit(0, 5, 1'b0, 1'b1);
    unit(5, 6, 1'b0, 1'b0);
    unit(11, 4, 1'b0, 1'b1);
    unit(15, 2, 1'b1, 1'b1);
    drain();
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    @(posedge clk);
    check(32'(aligned), 32'h0);
    unit(17, 2, 1'b0, 1'b1);
    drain();
    check(32'(aligned), 32'h1);
    stall <= 1'b1;
    send(8'h05, 1'b1, 1'b0);
    for (int i = 0; i < 40; i++) send(8'h40 + 8'(i), 1'b0, 1'b0);
    inValid <= 1'b0;
    drain();
    check(32'(stalled), 32'h1);
    check(32'(outValid), 32'h0);
    check(wireReg, 32'h0000_0107);
    finalReport();
  end
endmodule
`default_nettype wire
